// ### core/tdvm_pkg.sv
// Package for the time-dependent voltage monitor: widths, encodings and timing counts
package tdvm_pkg;
    localparam int VW          = 12;     // Voltage, 0.1 % of rated per LSB
    localparam int TW          = 16;     // Curve time, 10 ms per LSB
    localparam int NPTS        = 7;
    localparam int NMON        = 3;
    localparam int NFLAG       = 32;
    localparam int CLK_HZ      = 100_000_000;
    localparam int TICK_US     = 10_000; // Curve time unit in microseconds
    localparam int TICK_CYC    = TICK_US * (CLK_HZ / 1_000_000);
    localparam int BLOCK_S     = 5;      // Longest hold of the initiated signal
    localparam int BLOCK_TICKS = BLOCK_S * 1_000_000 / TICK_US;
    // Phase characteristic
    localparam logic [1:0] CHAR_ONE   = 2'h0;
    localparam logic [1:0] CHAR_TWO   = 2'h1;
    localparam logic [1:0] CHAR_THREE = 2'h2;
    // Enable source
    localparam logic [1:0] EN_ALWAYS  = 2'h0;
    localparam logic [1:0] EN_LOCK    = 2'h1;
    localparam logic [1:0] EN_FLAG    = 2'h2;
    // Alarm class, class B after reset
    localparam logic [2:0] ACLASS_RST = 3'h1;
    // Measurement selection
    localparam logic [1:0] MEAS_PP    = 2'h0;
    localparam logic [1:0] MEAS_PN    = 2'h1;
    localparam logic [1:0] MEAS_ALL   = 2'h2;
    typedef enum logic [1:0] {
        TDVM_IDLE = 2'b01,
        TDVM_RUN  = 2'b10
    } tdvm_state_t;
endpackage

// ### core/tdvm_top.sv
// Three-instance time-dependent voltage monitor with ride-through curves
// Contract
// - Three independent monitors, each own curve
// - Seven points, linear interpolation over time
// - Selectable undervoltage or overvoltage supervision
// - Sequence starts when phases cross initial threshold
// - Crossing the curve trips the monitor
// - Fallback held long enough resets sequence
// - Trip on one, two or three phases
// - Decoupling only while generator runs parallel
// - Under "all", four-wire uses both; three-wire phase-neutral only
// - Alarm class A to F or Control, B default
// - Self-acknowledge clears alarm when fault gone
// - Otherwise alarm held until acknowledged
// - Lock option monitors only while lock inactive
// - Flag option monitors while chosen flag true
// - Initiation flag set at start, cleared in band
// - Flags ORed, initiated held at most 5 s
// - Inverted initiated drives rate monitor enable
`timescale 1ns/1ps
`default_nettype none
module tdvm_top
    import tdvm_pkg::*;
#(
    parameter int TICK_CYCLES  = tdvm_pkg::TICK_CYC,
    parameter int BLOCK_TICKSP = tdvm_pkg::BLOCK_TICKS
) (
    input  wire logic                                   CLK,
    input  wire logic                                   SRST,
    input  wire logic [2:0][tdvm_pkg::VW-1:0]           PHASE_PN,
    input  wire logic [2:0][tdvm_pkg::VW-1:0]           PHASE_PP,
    input  wire logic                                   FOUR_WIRE,
    input  wire logic [1:0]                             MEAS_SEL,
    input  wire logic [2:0]                             MON_ON,
    input  wire logic [2:0]                             OVER_MODE,
    input  wire logic [2:0][1:0]                        CHAR_SEL,
    input  wire logic [2:0][tdvm_pkg::VW-1:0]           INIT_LEVEL,
    input  wire logic [2:0][tdvm_pkg::VW-1:0]           FALLBACK_LEVEL,
    input  wire logic [2:0][tdvm_pkg::TW-1:0]           FALLBACK_TIME,
    input  wire logic [2:0][6:0][tdvm_pkg::TW-1:0]      CURVE_TIME,
    input  wire logic [2:0][6:0][tdvm_pkg::VW-1:0]      CURVE_LEVEL,
    input  wire logic [2:0][2:0]                        ALARM_CLASS_IN,
    input  wire logic [2:0]                             SELF_ACK,
    input  wire logic                                   ACK,
    input  wire logic [2:0][1:0]                        ENABLE_SEL,
    input  wire logic [2:0][4:0]                        FLAG_SEL,
    input  wire logic                                   LOCK_MONITORING,
    input  wire logic [31:0]                            USER_CONDITION_BIT,
    input  wire logic                                   PARALLEL_RUN,
    output logic [2:0]                                  TRIP,
    output logic [2:0]                                  ALARM,
    output logic [2:0][2:0]                             ALARM_CLASS,
    output logic [2:0]                                  DECOUPLE,
    output logic [2:0]                                  INITIATED,
    output logic                                        ROCOF_ENABLE
);
    import tdvm_pkg::*;

    localparam int CW = 32;

    typedef struct packed {
        logic [CW-1:0]         tick_cnt;
        logic                  tick;
        tdvm_state_t [2:0]     st;
        logic [2:0][TW-1:0]    elapsed;
        logic [2:0][TW-1:0]    fb_cnt;
        logic [2:0]            trip;
        logic [2:0]            alarm;
        logic [2:0]            init_flag;
        logic [2:0][2:0]       aclass;
        logic [CW-1:0]         blk_cnt;
        logic                  blk;
    } tdvm_state_s_t;

    tdvm_state_s_t s_reg;
    tdvm_state_s_t s_next;

    // Comparison helpers: "beyond" means on the fault side of a level
    function automatic logic beyond(input logic ov, input logic [VW-1:0] v,
                                    input logic [VW-1:0] lvl);
        beyond = ov ? (v > lvl) : (v < lvl);
    endfunction

    function automatic logic [1:0] cnt3(input logic [2:0] b);
        cnt3 = {1'b0, b[0]} + {1'b0, b[1]} + {1'b0, b[2]};
    endfunction

    function automatic logic meets(input logic [1:0] ch, input logic [1:0] n);
        unique case (ch)
            CHAR_TWO:   meets = n >= 2'h2;
            CHAR_THREE: meets = n == 2'h3;
            default:    meets = n >= 2'h1;
        endcase
    endfunction

    // Threshold at elapsed time t between neighbouring points
    // Points with equal times give a step; their empty span is skipped, so no divide by zero
    function automatic logic [VW-1:0] interp(input logic [6:0][TW-1:0] ct,
                                             input logic [6:0][VW-1:0] cl,
                                             input logic [TW-1:0] t);
        logic [VW-1:0] r;
        logic [TW-1:0] dt;
        logic [TW-1:0] span;
        logic signed [VW+TW+1:0] prod;
        r = cl[0];
        dt = '0;
        span = '0;
        prod = '0;
        for (int k = 0; k < NPTS - 1; k++) begin
            if (t >= ct[k] && t < ct[k+1]) begin
                dt = t - ct[k];
                span = ct[k+1] - ct[k];
                prod = (signed'({2'b00, cl[k+1]}) - signed'({2'b00, cl[k]}))
                       * signed'({2'b00, dt});
                r = VW'(signed'({2'b00, cl[k]}) + prod / signed'({2'b00, span}));
            end
        end
        if (t >= ct[NPTS-1]) begin
            r = cl[NPTS-1];
        end
        interp = r;
    endfunction

    logic [2:0] mon_en;
    logic [2:0] any_init;

    always_comb begin
        logic [2:0] pn_init, pp_init, pn_crv, pp_crv, pn_fb, pp_fb;
        logic       use_pn, use_pp, hit_init, hit_crv, all_back;
        logic [VW-1:0] thr;
        s_next = s_reg;
        pn_init = '0;
        pp_init = '0;
        pn_crv = '0;
        pp_crv = '0;
        pn_fb = '0;
        pp_fb = '0;
        use_pn = 1'b0;
        use_pp = 1'b0;
        hit_init = 1'b0;
        hit_crv = 1'b0;
        all_back = 1'b0;
        thr = '0;
        mon_en = '0;
        any_init = '0;
        s_next.tick = 1'b0;
        if (s_reg.tick_cnt >= CW'(TICK_CYCLES - 1)) begin
            s_next.tick_cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + CW'(1);
        end
        // Three-wire systems only give phase-neutral values under "all"
        use_pn = (MEAS_SEL != MEAS_PP);
        use_pp = (MEAS_SEL == MEAS_PP) || (MEAS_SEL == MEAS_ALL && FOUR_WIRE);
        for (int m = 0; m < NMON; m++) begin
            unique case (ENABLE_SEL[m])
                EN_LOCK: mon_en[m] = MON_ON[m] && !LOCK_MONITORING;
                EN_FLAG: mon_en[m] = MON_ON[m] && USER_CONDITION_BIT[FLAG_SEL[m]];
                default: mon_en[m] = MON_ON[m];
            endcase
            thr = interp(CURVE_TIME[m], CURVE_LEVEL[m], s_reg.elapsed[m]);
            for (int p = 0; p < 3; p++) begin
                pn_init[p] = beyond(OVER_MODE[m], PHASE_PN[p], INIT_LEVEL[m]);
                pp_init[p] = beyond(OVER_MODE[m], PHASE_PP[p], INIT_LEVEL[m]);
                pn_crv[p]  = beyond(OVER_MODE[m], PHASE_PN[p], thr);
                pp_crv[p]  = beyond(OVER_MODE[m], PHASE_PP[p], thr);
                pn_fb[p]   = !beyond(OVER_MODE[m], PHASE_PN[p], FALLBACK_LEVEL[m]);
                pp_fb[p]   = !beyond(OVER_MODE[m], PHASE_PP[p], FALLBACK_LEVEL[m]);
            end
            hit_init = (use_pn && meets(CHAR_SEL[m], cnt3(pn_init)))
                    || (use_pp && meets(CHAR_SEL[m], cnt3(pp_init)));
            hit_crv  = (use_pn && meets(CHAR_SEL[m], cnt3(pn_crv)))
                    || (use_pp && meets(CHAR_SEL[m], cnt3(pp_crv)));
            all_back = (!use_pn || &pn_fb) && (!use_pp || &pp_fb);
            s_next.aclass[m] = ALARM_CLASS_IN[m];
            unique case (s_reg.st[m])
                TDVM_IDLE: begin
                    s_next.trip[m] = 1'b0;
                    if (mon_en[m] && hit_init) begin
                        s_next.st[m] = TDVM_RUN;
                        s_next.elapsed[m] = '0;
                        s_next.fb_cnt[m] = '0;
                        s_next.init_flag[m] = 1'b1;
                    end
                end
                TDVM_RUN: begin
                    if (s_reg.tick && s_reg.elapsed[m] < CURVE_TIME[m][NPTS-1]) begin
                        s_next.elapsed[m] = s_reg.elapsed[m] + TW'(1);
                    end
                    s_next.trip[m] = hit_crv;
                    if (all_back) begin
                        s_next.init_flag[m] = 1'b0;
                        if (s_reg.tick) begin
                            s_next.fb_cnt[m] = s_reg.fb_cnt[m] + TW'(1);
                        end
                        if (s_reg.fb_cnt[m] >= FALLBACK_TIME[m]) begin
                            s_next.st[m] = TDVM_IDLE;
                            s_next.trip[m] = 1'b0;
                        end
                    end else begin
                        s_next.fb_cnt[m] = '0;
                    end
                    if (!mon_en[m]) begin
                        s_next.st[m] = TDVM_IDLE;
                        s_next.trip[m] = 1'b0;
                        s_next.init_flag[m] = 1'b0;
                    end
                end
                default: s_next.st[m] = TDVM_IDLE;
            endcase
            // Latched alarm: a trip in the acknowledge cycle still wins
            if (s_next.trip[m]) begin
                s_next.alarm[m] = 1'b1;
            end else if (SELF_ACK[m]) begin
                s_next.alarm[m] = 1'b0;
            end else if (ACK) begin
                s_next.alarm[m] = 1'b0;
            end
            any_init[m] = s_next.init_flag[m];
        end
        // Blocking ends after the limit even if a flag stays set
        if (|any_init) begin
            if (!s_reg.blk && s_reg.blk_cnt == '0) begin
                s_next.blk = 1'b1;
            end
            if (s_reg.blk && s_reg.tick) begin
                s_next.blk_cnt = s_reg.blk_cnt + CW'(1);
            end
            if (s_reg.blk_cnt >= CW'(BLOCK_TICKSP)) begin
                s_next.blk = 1'b0;
            end
        end else begin
            s_next.blk = 1'b0;
            s_next.blk_cnt = '0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_reg <= '0;
            s_reg.st <= {TDVM_IDLE, TDVM_IDLE, TDVM_IDLE};
            s_reg.aclass <= {ACLASS_RST, ACLASS_RST, ACLASS_RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign TRIP = s_reg.trip;
    assign ALARM = s_reg.alarm;
    assign ALARM_CLASS = s_reg.aclass;
    assign DECOUPLE = s_reg.trip & {3{PARALLEL_RUN}};
    assign INITIATED = s_reg.init_flag;
    assign ROCOF_ENABLE = !s_reg.blk;

    decouple_gate_a: assert property (@(posedge CLK) disable iff (SRST)
        !PARALLEL_RUN |-> DECOUPLE == 3'h0)
        else $error("decoupling while not parallel");
    rocof_inv_a: assert property (@(posedge CLK) disable iff (SRST)
        $rose(|INITIATED) |-> !ROCOF_ENABLE)
        else $error("rate monitor not blocked");
    block_limit_a: assert property (@(posedge CLK) disable iff (SRST)
        s_reg.blk |-> s_reg.blk_cnt <= CW'(BLOCK_TICKSP))
        else $error("initiated held too long");
    trip_idle_a: assert property (@(posedge CLK) disable iff (SRST)
        s_reg.trip[0] |-> $past(s_reg.st[0]) == TDVM_RUN)
        else $error("trip outside a sequence");
    alarm_hold_a: assert property (@(posedge CLK) disable iff (SRST)
        (s_reg.alarm[0] && !SELF_ACK[0] && !ACK) |=> s_reg.alarm[0])
        else $error("alarm dropped without acknowledge");
    self_ack_a: assert property (@(posedge CLK) disable iff (SRST)
        (SELF_ACK[1] && !s_next.trip[1]) |=> !s_reg.alarm[1])
        else $error("self acknowledge failed");
    lock_en_a: assert property (@(posedge CLK) disable iff (SRST)
        (ENABLE_SEL[0] == EN_LOCK && LOCK_MONITORING) |=> s_reg.st[0] == TDVM_IDLE)
        else $error("monitor ran while locked");
    flag_start_a: assert property (@(posedge CLK) disable iff (SRST)
        ($past(s_reg.st[2]) == TDVM_IDLE && s_reg.st[2] == TDVM_RUN) |-> INITIATED[2])
        else $error("initiation flag not set");
    // Fallback count can only pass its limit on the edge that ends the sequence
    fb_bound_a: assert property (@(posedge CLK) disable iff (SRST)
        s_reg.st[0] == TDVM_RUN |-> s_reg.fb_cnt[0] <= FALLBACK_TIME[0])
        else $error("fallback time overrun");
    // Curve time only moves on a tick, so the threshold steps at the tick rate
    elapsed_step_a: assert property (@(posedge CLK) disable iff (SRST)
        (s_reg.st[0] == TDVM_RUN && !s_reg.tick) |=> $stable(s_reg.elapsed[0]))
        else $error("elapsed time moved off a tick");
    // A disabled monitor must drop its sequence at once
    flag_gate_a: assert property (@(posedge CLK) disable iff (SRST)
        (ENABLE_SEL[2] == EN_FLAG && !USER_CONDITION_BIT[FLAG_SEL[2]])
            |=> s_reg.st[2] == TDVM_IDLE)
        else $error("monitor ran with its flag low");
    trip_clear_a: assert property (@(posedge CLK) disable iff (SRST)
        s_reg.st[1] == TDVM_IDLE |=> !s_reg.trip[1])
        else $error("trip held after sequence end");
    // The class is taken one edge late; a change mid-trip applies from then on
    class_follow_a: assert property (@(posedge CLK) disable iff (SRST)
        1'b1 |=> ALARM_CLASS == $past(ALARM_CLASS_IN))
        else $error("alarm class not applied");
endmodule // tdvm_top
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the time-dependent voltage monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import tdvm_pkg::*;
    logic CLK = 0, SRST = 1, FOUR_WIRE = 0, ACK = 0, LOCK_MONITORING = 0, PARALLEL_RUN = 1;
    logic [1:0] MEAS_SEL = MEAS_PN;
    logic [2:0] MON_ON = 3'h7, OVER_MODE = 3'h2, SELF_ACK = 3'h7;
    logic [2:0][1:0] CHAR_SEL = {CHAR_TWO, CHAR_THREE, CHAR_ONE};
    logic [2:0][1:0] ENABLE_SEL = {EN_FLAG, EN_ALWAYS, EN_ALWAYS};
    logic [2:0][4:0] FLAG_SEL = {5'h1F, 5'h00, 5'h00};
    logic [31:0] USER_CONDITION_BIT = 32'h0;
    logic [2:0][VW-1:0] INIT_LEVEL = {12'h320, 12'h44C, 12'h320};
    logic [2:0][VW-1:0] FALLBACK_LEVEL = {12'h384, 12'h41A, 12'h384};
    logic [2:0][TW-1:0] FALLBACK_TIME = {3{16'h0003}};
    logic [2:0][6:0][TW-1:0] CURVE_TIME;
    logic [2:0][6:0][VW-1:0] CURVE_LEVEL;
    logic [2:0][2:0] ALARM_CLASS_IN = {3'h1, 3'h6, 3'h1};
    logic [2:0][VW-1:0] lvl_req = {3{12'h3E8}}, pn, pp;
    logic [2:0] TRIP, ALARM, DECOUPLE, INITIATED;
    logic [2:0][2:0] ALARM_CLASS;
    logic ROCOF_ENABLE;
    int errors = 0, checks_done = 0, i;
    always #5 CLK = ~CLK;
    // Rising curve on monitors 0 and 2: 45 %, 70 % then 90 %; monitor 1 flat at 120 %; ascending times two ticks apart
    initial for (int m = 0; m < 3; m++) for (int p = 0; p < 7; p++) begin
        CURVE_TIME[m][p] = 16'(2 * p);
        CURVE_LEVEL[m][p] = (m == 1) ? 12'h4B0 : (p < 2) ? 12'h1C2 : (p < 4) ? 12'h2BC : 12'h384;
    end
    tdvm_meas_model u_meas (.lvl_req(lvl_req), .phase_pn(pn), .phase_pp(pp));
    tdvm_top #(.TICK_CYCLES(10), .BLOCK_TICKSP(5)) u_dut (.CLK(CLK), .SRST(SRST),
        .PHASE_PN(pn), .PHASE_PP(pp), .FOUR_WIRE(FOUR_WIRE), .MEAS_SEL(MEAS_SEL),
        .MON_ON(MON_ON), .OVER_MODE(OVER_MODE), .CHAR_SEL(CHAR_SEL), .INIT_LEVEL(INIT_LEVEL),
        .FALLBACK_LEVEL(FALLBACK_LEVEL), .FALLBACK_TIME(FALLBACK_TIME),
        .CURVE_TIME(CURVE_TIME), .CURVE_LEVEL(CURVE_LEVEL), .ALARM_CLASS_IN(ALARM_CLASS_IN),
        .SELF_ACK(SELF_ACK), .ACK(ACK), .ENABLE_SEL(ENABLE_SEL), .FLAG_SEL(FLAG_SEL),
        .LOCK_MONITORING(LOCK_MONITORING), .USER_CONDITION_BIT(USER_CONDITION_BIT),
        .PARALLEL_RUN(PARALLEL_RUN), .TRIP(TRIP), .ALARM(ALARM), .ALARM_CLASS(ALARM_CLASS),
        .DECOUPLE(DECOUPLE), .INITIATED(INITIATED), .ROCOF_ENABLE(ROCOF_ENABLE));
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // Back to nominal, then long enough for the fallback time to run out
    task automatic recover();
        lvl_req = {3{12'h3E8}};
        cyc(60);
    endtask
    task automatic t_reset();
        `CHK("TRIP", 3'h0, TRIP)
        `CHK("ALARM_CLASS", {3'h1, 3'h6, 3'h1}, ALARM_CLASS)
        `CHK("ROCOF_ENABLE", 1'b1, ROCOF_ENABLE)
        $display("t_reset done");
    endtask
    task automatic t_under();
        lvl_req[0] = 12'h2EE;
        cyc(2);
        `CHK("INITIATED", 3'h1, INITIATED)
        `CHK("ROCOF_ENABLE", 1'b0, ROCOF_ENABLE)
        cyc(28);
        `CHK("TRIP early", 1'b0, TRIP[0])
        for (i = 0; i < 200 && TRIP[0] !== 1'b1; i++) cyc(1);
        `CHK("TRIP", 3'h1, TRIP)
        cyc(2);
        `CHK("ALARM", 1'b1, ALARM[0])
        `CHK("DECOUPLE", 3'h1, DECOUPLE)
        `CHK("ROCOF_ENABLE held", 1'b1, ROCOF_ENABLE)
        `CHK("INITIATED held", 3'h1, INITIATED)
        PARALLEL_RUN = 1'b0;
        cyc(1);
        `CHK("DECOUPLE off", 3'h0, DECOUPLE)
        PARALLEL_RUN = 1'b1;
        lvl_req[0] = 12'h3E8;
        cyc(3);
        `CHK("INITIATED clear", 3'h0, INITIATED)
        `CHK("ALARM self ack", 1'b0, ALARM[0])
        cyc(60);
        `CHK("TRIP idle", 3'h0, TRIP)
        // A fresh dip must restart at the curve's first point, not trip at once
        lvl_req[0] = 12'h2EE;
        cyc(2);
        `CHK("INITIATED restart", 3'h1, INITIATED)
        `CHK("TRIP restart", 1'b0, TRIP[0])
        recover();
        $display("t_under done");
    endtask
    task automatic t_ack();
        SELF_ACK[0] = 1'b0;
        lvl_req[0] = 12'h12C;
        for (i = 0; i < 50 && TRIP[0] !== 1'b1; i++) cyc(1);
        recover();
        `CHK("ALARM latched", 1'b1, ALARM[0])
        ACK = 1'b1;
        cyc(2);
        ACK = 1'b0;
        `CHK("ALARM acked", 1'b0, ALARM[0])
        SELF_ACK[0] = 1'b1;
        $display("t_ack done");
    endtask
    task automatic t_lock();
        ENABLE_SEL[0] = EN_LOCK;
        LOCK_MONITORING = 1'b1;
        lvl_req[0] = 12'h12C;
        cyc(5);
        `CHK("INITIATED locked", 1'b0, INITIATED[0])
        LOCK_MONITORING = 1'b0;
        cyc(3);
        `CHK("INITIATED unlocked", 1'b1, INITIATED[0])
        recover();
        ENABLE_SEL[0] = EN_ALWAYS;
        $display("t_lock done");
    endtask
    task automatic t_flag_over();
        lvl_req = {12'h3E8, 12'h12C, 12'h12C};
        cyc(5);
        `CHK("INITIATED flag low", 1'b0, INITIATED[2])
        USER_CONDITION_BIT[31] = 1'b1;
        cyc(3);
        `CHK("INITIATED flag high", 1'b1, INITIATED[2])
        recover();
        USER_CONDITION_BIT[31] = 1'b0;
        lvl_req = {12'h3E8, 12'h514, 12'h514};
        cyc(30);
        `CHK("TRIP two of three", 1'b0, TRIP[1])
        lvl_req[2] = 12'h514;
        cyc(5);
        `CHK("TRIP over", 1'b1, TRIP[1])
        `CHK("ALARM_CLASS control", 3'h6, ALARM_CLASS[1])
        recover();
        $display("t_flag_over done");
    endtask
    // Phase-phase stays nominal, so only the phase-neutral path can start
    task automatic t_meas();
        MEAS_SEL = MEAS_PP;
        lvl_req[0] = 12'h2EE;
        cyc(5);
        `CHK("INITIATED pp only", 3'h0, INITIATED)
        MEAS_SEL = MEAS_ALL;
        FOUR_WIRE = 1'b1;
        cyc(3);
        `CHK("INITIATED all", 3'h1, INITIATED)
        recover();
        FOUR_WIRE = 1'b0;
        MEAS_SEL = MEAS_PN;
        $display("t_meas done");
    endtask
    task automatic conclude();
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        cyc(16);
        SRST = 1'b0;
        cyc(2);
        t_reset();
        t_under();
        t_ack();
        t_lock();
        t_flag_over();
        t_meas();
        conclude();
    end
    // Tests need about 600 cycles; allow over sixteen times that
    initial begin
        #100_000;
        errors++;
        conclude();
    end
endmodule // tb_top
`default_nettype wire

// ### verif/tdvm_meas_model.sv
// Measurement front end model: presents phase samples requested by the bench
`timescale 1ns/1ps
`default_nettype none
module tdvm_meas_model
    import tdvm_pkg::*;
#(
    parameter logic [tdvm_pkg::VW-1:0] PP_NOMINAL = 12'h3E8
) (
    input  wire logic [2:0][tdvm_pkg::VW-1:0] lvl_req,
    output logic      [2:0][tdvm_pkg::VW-1:0] phase_pn,
    output logic      [2:0][tdvm_pkg::VW-1:0] phase_pp
);
    // Phase-phase held at nominal so only the phase-neutral path can start a sequence
    assign phase_pn = lvl_req;
    assign phase_pp = {3{PP_NOMINAL}};
endmodule // tdvm_meas_model
`default_nettype wire
